/* rtl/std_timer.sv */
// Sixteen-bit count-up timer with compare, PWM and Avalon-MM registers
//
// Decided for this implementation: the address map and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "timer_map.svh"

module std_timer (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             sys_rst,
	// Avalon-MM slave
	input  wire timer_pkg::avl_req_t avl_req,
	output logic [31:0]           avl_readdata,
	output logic                  avl_waitrequest,
	// Timer pins
	input  wire logic             ext_clock_pin,
	input  wire logic             sub_clock_pin,
	output logic                  timer_output_pin,
	output logic                  timer_output_oe
);

	// ==========================================
	// State
	// ==========================================
	timer_pkg::timer_state_t q_reg;
	timer_pkg::timer_state_t q_next;

	// Decoded control fields
	logic       run;
	logic       count_pause;
	logic [2:0] clock_select;
	logic [1:0] op_mode;
	logic [1:0] pin_action;
	logic       output_initial_level;
	logic       output_invert;
	logic       period_duty_swap;
	logic       clear_source_select;

	// Datapath terms
	logic        start;
	logic        tick;
	logic        active;
	logic [16:0] inc;
	logic        hit_a;
	logic        hit_p;
	logic        clr;
	logic [16:0] duty;
	logic [16:0] period;
	logic        pwm_on;
	logic        is_pwm;
	logic [3:0]  idx;
	logic        acc;

	// ==========================================
	// Field decode
	// ==========================================
	assign run                  = q_reg.ctrl0[`C0_RUN];
	assign count_pause          = q_reg.ctrl0[`C0_PAUSE];
	assign clock_select         = q_reg.ctrl0[6:4];
	assign op_mode              = q_reg.ctrl1[7:6];
	assign pin_action           = q_reg.ctrl1[5:4];
	assign output_initial_level = q_reg.ctrl1[`C1_OC];
	assign output_invert        = q_reg.ctrl1[`C1_INV];
	assign period_duty_swap     = q_reg.ctrl1[`C1_SWAP];
	assign clear_source_select  = q_reg.ctrl1[`C1_CCLR];
	assign is_pwm               = (op_mode == `MODE_PWM);

	// Run rising edge, seen one cycle after the write
	assign start = run && !q_reg.run_d;

	// ==========================================
	// Clock source selection
	// ==========================================
	// Prescaler taps and synchronised pin edges all become one-cycle ticks,
	// so the counter stays in the system domain. Stage 0 of each pin
	// synchroniser feeds stage 1 only; edges compare stages 1 and 2.
	always_comb begin
		case (clock_select)
			`CK_SYS4: tick = (q_reg.pre[1:0] == 2'h3);
			`CK_SYS:  tick = 1'b1;
			`CK_H16:  tick = (q_reg.pre[3:0] == 4'hF);
			`CK_H64:  tick = (q_reg.pre == 6'h3F);
			`CK_SUB:  tick = q_reg.sub_s[1] && !q_reg.sub_s[2];
			`CK_H8:   tick = (q_reg.pre[2:0] == 3'h7);
			`CK_EXT_R: tick = q_reg.ext_s[1] && !q_reg.ext_s[2];
			`CK_EXT_F: tick = !q_reg.ext_s[1] && q_reg.ext_s[2];
			default:  tick = 1'b0;
		endcase
	end

	// Counter advances only while running and not paused
	assign active = run && !count_pause && !start && tick;

	// ==========================================
	// Comparators
	// ==========================================
	// Matches look at the value the counter is about to take, so the
	// period is exactly compare-P times 256 counts.
	assign inc = {1'b0, q_reg.cnt} + 17'h00001;

	// P matches its byte in the top byte with the low byte zero; zero means the natural wrap
	assign hit_p = (q_reg.cmpp == 8'h00) ? inc[16] :
		(inc[15:0] == {q_reg.cmpp, 8'h00});

	// A compares all bits; zero never matches, the wrap is silent
	assign hit_a = (q_reg.cmpa != 16'h0000) &&
		(inc[15:0] == q_reg.cmpa);

	// Clear source: swap bit in PWM, clear select otherwise
	always_comb begin
		if (is_pwm) begin
			clr = period_duty_swap ? hit_a : hit_p;
		end else begin
			clr = clear_source_select ? hit_a : hit_p;
		end
	end

	// ==========================================
	// PWM period and duty
	// ==========================================
	always_comb begin
		if (period_duty_swap) begin
			period = (q_reg.cmpa == 16'h0000) ? 17'h10000 :
				{1'b0, q_reg.cmpa};
			duty   = (q_reg.cmpp == 8'h00) ? 17'h10000 :
				{1'b0, q_reg.cmpp, 8'h00};
		end else begin
			period = (q_reg.cmpp == 8'h00) ? 17'h10000 :
				{1'b0, q_reg.cmpp, 8'h00};
			duty   = {1'b0, q_reg.cmpa};
		end
	end

	// Counter never reaches the period, so duty at or above it is always on
	assign pwm_on = ({1'b0, q_reg.cnt} < duty);

	// ==========================================
	// Bus decode
	// ==========================================
	// Request is taken on the edge where waitrequest is seen low
	assign idx = avl_req.address[5:2];
	assign acc = (avl_req.read || avl_req.write) && !q_reg.waitreq;

	// ==========================================
	// Next state
	// ==========================================
	always_comb begin
		q_next = q_reg;

		// Free-running prescaler and pin synchronisers
		q_next.pre   = q_reg.pre + 6'h01;
		q_next.ext_s = {q_reg.ext_s[1:0], ext_clock_pin};
		q_next.sub_s = {q_reg.sub_s[1:0], sub_clock_pin};
		q_next.run_d = run;

		// Counter: no software write path exists
		if (start) begin
			q_next.cnt = 16'h0000;
		end else if (active) begin
			q_next.cnt = clr ? 16'h0000 : inc[15:0];
		end

		// Match flags; counting goes on whatever the pin does
		if (active && hit_a) begin
			q_next.flag_a = 1'b1;
		end
		if (active && hit_p && (is_pwm || !clear_source_select)) begin
			q_next.flag_p = 1'b1;
		end

		// Compare mode pin level
		if (start) begin
			q_next.pin_lvl = output_initial_level;
		end else if (active && hit_a && !is_pwm) begin
			case (pin_action)
				2'h1:    q_next.pin_lvl = 1'b0;
				2'h2:    q_next.pin_lvl = 1'b1;
				2'h3:    q_next.pin_lvl = !q_reg.pin_lvl;
				default: q_next.pin_lvl = q_reg.pin_lvl;
			endcase
		end

		// Pin drive; timer mode and the undefined mode leave it free
		q_next.pin_oe = run &&
			((op_mode == `MODE_CMP) || is_pwm);
		if (is_pwm) begin
			case (pin_action)
				2'h1:    q_next.pin_out = output_initial_level;
				2'h2:    q_next.pin_out = pwm_on ?
					output_initial_level : !output_initial_level;
				default: q_next.pin_out = !output_initial_level;
			endcase
			q_next.pin_out = q_next.pin_out ^ output_invert;
		end else begin
			q_next.pin_out = q_next.pin_lvl ^ output_invert;
		end

		// Avalon handshake: one wait cycle, then the answer
		q_next.waitreq = !((avl_req.read || avl_req.write) && q_reg.waitreq);
		case (idx)
			`IDX_CTRL0:   q_next.rdata = {24'h0, q_reg.ctrl0};
			`IDX_CTRL1:   q_next.rdata = {24'h0, q_reg.ctrl1};
			`IDX_CNT_LO:  q_next.rdata = {24'h0, q_reg.cnt[7:0]};
			`IDX_CNT_HI:  q_next.rdata = {24'h0, q_reg.cnt[15:8]};
			`IDX_CMPA_LO: q_next.rdata = {24'h0, q_reg.cmpa[7:0]};
			`IDX_CMPA_HI: q_next.rdata = {24'h0, q_reg.cmpa[15:8]};
			`IDX_CMPP:    q_next.rdata = {24'h0, q_reg.cmpp};
			`IDX_STATUS:  q_next.rdata = {30'h0, q_reg.flag_p, q_reg.flag_a};
			default:      q_next.rdata = 32'h0000_0000;
		endcase

		// Register writes; counter registers ignore them
		if (acc && avl_req.write) begin
			case (idx)
				`IDX_CTRL0: q_next.ctrl0 = avl_req.writedata[7:0] & `C0_WMASK;
				`IDX_CTRL1: q_next.ctrl1 = avl_req.writedata[7:0];
				`IDX_CMPA_LO: q_next.cmpa[7:0] = avl_req.writedata[7:0];
				`IDX_CMPA_HI: q_next.cmpa[15:8] = avl_req.writedata[7:0];
				`IDX_CMPP:  q_next.cmpp = avl_req.writedata[7:0];
				`IDX_STATUS: begin
					// Set wins over a clear in the same cycle
					if (avl_req.writedata[`ST_FLAG_A] && !(active && hit_a)) begin
						q_next.flag_a = 1'b0;
					end
					if (avl_req.writedata[`ST_FLAG_P] && q_reg.flag_p &&
						!(active && hit_p)) begin
						q_next.flag_p = 1'b0;
					end
				end
				default: q_next.cmpp = q_reg.cmpp;
			endcase
		end
	end

	// ==========================================
	// State register
	// ==========================================
	always_ff @(posedge sys_clk) begin
		if (sys_rst) begin
			q_reg <= '0;
			q_reg.waitreq <= 1'b1;
		end else begin
			q_reg <= q_next;
		end
	end

	// Outputs straight from the state register
	assign avl_readdata     = q_reg.rdata;
	assign avl_waitrequest  = q_reg.waitreq;
	assign timer_output_pin = q_reg.pin_out;
	assign timer_output_oe  = q_reg.pin_oe;

	// ==========================================
	// Assertions
	// ==========================================
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (sys_rst);

	// Start clears the counter
	property p_start_clear;
		start |=> (q_reg.cnt == 16'h0000);
	endproperty
	a_start_clear: assert property (p_start_clear)
		else $error("counter not cleared on start");

	// Start restores the initial pin level
	property p_start_level;
		start |=> (q_reg.pin_lvl == $past(output_initial_level));
	endproperty
	a_start_level: assert property (p_start_level)
		else $error("pin level not restored on start");

	// Clear on A outside PWM never raises the P flag
	property p_no_flag_p;
		(!is_pwm && clear_source_select && !q_reg.flag_p) |=> !q_reg.flag_p;
	endproperty
	a_no_flag_p: assert property (p_no_flag_p)
		else $error("P flag set while clearing on A");

	// Timer mode releases the pin
	property p_tc_free;
		(op_mode == `MODE_TC) |=> !timer_output_oe;
	endproperty
	a_tc_free: assert property (p_tc_free)
		else $error("pin driven in timer mode");

	// Pause holds the count
	property p_pause;
		(count_pause && !start) |=> $stable(q_reg.cnt);
	endproperty
	a_pause: assert property (p_pause)
		else $error("counter moved while paused");

	// P match clears and flags in compare mode
	property p_p_clear;
		(active && hit_p && !is_pwm && !clear_source_select)
			|=> (q_reg.cnt == 16'h0000) && q_reg.flag_p;
	endproperty
	a_p_clear: assert property (p_p_clear)
		else $error("P match did not clear and flag");

	// Full duty keeps the pin active
	property p_full_duty;
		(is_pwm && pin_action == 2'h2 && duty >= period &&
			({1'b0, q_reg.cnt} < period))
			|=> (timer_output_pin == ($past(output_initial_level) ^
			$past(output_invert)));
	endproperty
	a_full_duty: assert property (p_full_duty)
		else $error("full duty not held active");

	// Forced inactive level keeps counting alive
	property p_forced;
		(is_pwm && pin_action == 2'h0 && active && !clr)
			|=> (timer_output_pin == !($past(output_initial_level) ^
			$past(output_invert))) && (q_reg.cnt == $past(q_reg.cnt) + 16'h0001);
	endproperty
	a_forced: assert property (p_forced)
		else $error("forced PWM pin or stalled count");

	// A match drives low when asked
	property p_a_low;
		(active && hit_a && !is_pwm && !start && pin_action == 2'h1)
			|=> !q_reg.pin_lvl;
	endproperty
	a_a_low: assert property (p_a_low)
		else $error("A match did not drive low");

	// Clear on A in compare mode restarts the count
	property p_a_clear;
		(active && hit_a && !is_pwm && clear_source_select)
			|=> (q_reg.cnt == 16'h0000);
	endproperty
	a_a_clear: assert property (p_a_clear)
		else $error("A match did not clear the counter");

	// A P match alone leaves the compare pin level alone
	property p_p_keep;
		(active && hit_p && !hit_a && !is_pwm)
			|=> $stable(q_reg.pin_lvl);
	endproperty
	a_p_keep: assert property (p_p_keep)
		else $error("P match moved the pin level");

	// Toggle action inverts the level on every A match outside PWM
	property p_a_toggle;
		(active && hit_a && !is_pwm && pin_action == 2'h3)
			|=> (q_reg.pin_lvl != $past(q_reg.pin_lvl));
	endproperty
	a_a_toggle: assert property (p_a_toggle)
		else $error("A match did not toggle the pin");

	// Every A match raises its flag, whatever the mode
	property p_flag_a;
		(active && hit_a) |=> q_reg.flag_a;
	endproperty
	a_flag_a: assert property (p_flag_a)
		else $error("A match left its flag low");

	// Compare mode drives the pin while running
	property p_cmp_drive;
		(run && op_mode == `MODE_CMP) |=> timer_output_oe;
	endproperty
	a_cmp_drive: assert property (p_cmp_drive)
		else $error("pin not driven in compare mode");

	// Bus answers one cycle after a request
	property p_bus;
		((avl_req.read || avl_req.write) && avl_waitrequest) |=> !avl_waitrequest;
	endproperty
	a_bus: assert property (p_bus)
		else $error("bus answer late");

	// Main scenarios
	c_pwm_wave: cover property (is_pwm && pin_action == 2'h2 &&
		$rose(timer_output_pin));
	c_flag_p: cover property ($rose(q_reg.flag_p));
	c_flag_a: cover property ($rose(q_reg.flag_a));
	c_ext_tick: cover property (clock_select == `CK_EXT_R && active);

endmodule
`default_nettype wire

/* rtl/timer_map.svh */
// Register map, field positions and constants of the compare/PWM timer
`ifndef TIMER_MAP_SVH
`define TIMER_MAP_SVH

// Register word indices; byte address is four times the index
`define IDX_CTRL0     4'h0
`define IDX_CTRL1     4'h1
`define IDX_CNT_LO    4'h2
`define IDX_CNT_HI    4'h3
`define IDX_CMPA_LO   4'h4
`define IDX_CMPA_HI   4'h5
`define IDX_CMPP      4'h6
`define IDX_STATUS    4'h7

// Control 0 fields
`define C0_PAUSE      7
`define C0_RUN        3
`define C0_WMASK      8'hF8

// Control 1 fields
`define C1_CCLR       0
`define C1_SWAP       1
`define C1_INV        2
`define C1_OC         3

// Status fields, write one to clear
`define ST_FLAG_A     0
`define ST_FLAG_P     1

// Mode and clock select encodings
`define MODE_CMP      2'h0
`define MODE_PWM      2'h2
`define MODE_TC       2'h3
`define CK_SYS4       3'h0
`define CK_SYS        3'h1
`define CK_H16        3'h2
`define CK_H64        3'h3
`define CK_SUB        3'h4
`define CK_H8         3'h5
`define CK_EXT_R      3'h6
`define CK_EXT_F      3'h7

`endif

/* rtl/timer_pkg.sv */
// Types of the compare/PWM timer
package timer_pkg;

	// Avalon-MM request towards the slave
	typedef struct packed {
		logic [5:0]  address;
		logic        read;
		logic        write;
		logic [31:0] writedata;
	} avl_req_t;

	// Whole state of the timer
	typedef struct packed {
		logic [7:0]  ctrl0;
		logic [7:0]  ctrl1;
		logic [15:0] cmpa;
		logic [7:0]  cmpp;
		logic        flag_a;
		logic        flag_p;
		logic [15:0] cnt;
		logic        run_d;
		logic [5:0]  pre;
		logic [2:0]  ext_s;
		logic [2:0]  sub_s;
		logic        pin_lvl;
		logic        pin_out;
		logic        pin_oe;
		logic        waitreq;
		logic [31:0] rdata;
	} timer_state_t;

endpackage

/* tb/timer_pin_partner.sv */
// Far-side model: external count clock source, sub clock and output pad
`timescale 1ns/10ps
`default_nettype none

module timer_pin_partner (
	// Clock
	input  wire logic        sys_clk,
	// Pins from the timer
	input  wire logic        timer_output_pin,
	input  wire logic        timer_output_oe,
	// Pins towards the timer and the pad level seen outside
	output logic             ext_clock_pin,
	output wire logic        sub_clock_pin,
	output wire logic        pad,
	output logic [15:0]      gap
);
	// ==========================================
	// Pad and sub clock
	logic [2:0]  sub_div = 3'h0;
	logic [15:0] run_cnt = 16'h0000;
	logic        pad_q;

	// Pull-down: a released pad reads low, never the last driven level
	assign pad           = timer_output_oe ? timer_output_pin : 1'b0;
	assign sub_clock_pin = sub_div[2];

	// Free-running sub clock of 8 cycles; gap between pad changes
	always @(posedge sys_clk) begin
		sub_div <= sub_div + 3'h1;
		run_cnt <= run_cnt + 16'h0001;
		pad_q   <= pad;
		if (pad !== pad_q) begin
			gap     <= run_cnt + 16'h0001;
			run_cnt <= 16'h0000;
		end
	end

	// ==========================================
	// External clock bursts, still between bursts
	initial begin
		ext_clock_pin = 1'b0;
	end

	task automatic burst(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			ext_clock_pin <= 1'b1;
			repeat (4) @(posedge sys_clk);
			ext_clock_pin <= 1'b0;
			repeat (3) @(posedge sys_clk);
		end
	endtask
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench of the compare/PWM timer
`timescale 1ns/10ps
`default_nettype none

module tb;
	// ==========================================
	// Signals
	logic                sys_clk, sys_rst;
	timer_pkg::avl_req_t req;
	logic [31:0]         avl_readdata;
	logic                avl_waitrequest, pin, oe, ext_pin, sub_pin, pad;
	logic [15:0]         gap;
	int                  errors, checked, cycles;
	typedef struct {logic [5:0] a; logic [7:0] w; logic [7:0] e;} reg_row_t;
	typedef struct {logic [2:0] sel; int e;} ck_row_t;
	typedef struct {logic [7:0] c1; logic [15:0] ca; logic [7:0] cp; int hi; logic [7:0] f;} pwm_t;
	reg_row_t rr[8] = '{'{6'h04, 8'h5B, 8'h5B}, '{6'h10, 8'hA5, 8'hA5}, '{6'h14, 8'h3C, 8'h3C},
		'{6'h18, 8'hC3, 8'hC3}, '{6'h00, 8'hF5, 8'hF0}, '{6'h08, 8'hFF, 8'h00},
		'{6'h0C, 8'hFF, 8'h00}, '{6'h20, 8'h77, 8'h00}};
	ck_row_t ck[8] = '{'{3'h0, 256}, '{3'h1, 1024}, '{3'h2, 64}, '{3'h3, 16},
		'{3'h4, 128}, '{3'h5, 128}, '{3'h6, 10}, '{3'h7, 10}};
	pwm_t pw[7] = '{'{8'hA8, 16'h0040, 8'h01, 128, 8'h03}, '{8'hAA, 16'h0200, 8'h01, 256, 8'h03},
		'{8'hAC, 16'h0040, 8'h01, 384, 8'h03}, '{8'hA0, 16'h0040, 8'h01, 384, 8'h03},
		'{8'hA8, 16'h0200, 8'h01, 512, 8'h02}, '{8'h88, 16'h0040, 8'h01, 0, 8'h03},
		'{8'h98, 16'h0040, 8'h01, 512, 8'h03}};

	// ==========================================
	// Design and far side
	std_timer dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .avl_req(req),
		.avl_readdata(avl_readdata), .avl_waitrequest(avl_waitrequest),
		.ext_clock_pin(ext_pin), .sub_clock_pin(sub_pin),
		.timer_output_pin(pin), .timer_output_oe(oe));
	timer_pin_partner u_far (.sys_clk(sys_clk), .timer_output_pin(pin),
		.timer_output_oe(oe), .ext_clock_pin(ext_pin), .sub_clock_pin(sub_pin),
		.pad(pad), .gap(gap));

	// Clock of 20 ns
	initial begin
		sys_clk = 1'b0;
		forever #10 sys_clk = ~sys_clk;
	end

	// ==========================================
	// Checking and bus tasks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			errors++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// Holds the request until the edge that samples waitrequest low
	task automatic acc(input logic w, input logic [5:0] a, input logic [7:0] d,
		output logic [7:0] q);
		@(posedge sys_clk);
		req <= '{address: a, read: ~w, write: w, writedata: {24'h000000, d}};
		// No cycle count assumed; only the bench timeout ends a hang
		do begin
			@(posedge sys_clk);
		end while (avl_waitrequest !== 1'b0);
		q = avl_readdata[7:0];
		req <= '0;
	endtask

	task automatic wr(input logic [5:0] a, input logic [7:0] d);
		logic [7:0] q;
		acc(1'b1, a, d, q);
	endtask

	task automatic rd_chk(input logic [5:0] a, input logic [7:0] e);
		logic [7:0] q;
		acc(1'b0, a, 8'h00, q);
		check({8'h00, q}, {8'h00, e});
	endtask

	task automatic final_report();
		$display("comparisons %0d, mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	// Cuts a hang short
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 60000) begin
			errors++;
			final_report();
		end
	end

	// ==========================================
	// Main sequence
	initial begin
		logic [7:0] lo, hi;
		logic       oc;
		int         v, tol;
		errors = 0; checked = 0; cycles = 0;
		sys_rst = 1'b1;
		req = '0;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		check(avl_waitrequest, 16'h0001);
		check(oe, 16'h0000);
		for (int i = 0; i < 8; i++) rd_chk(6'(i * 4), 8'h00);
		foreach (rr[i]) begin
			wr(rr[i].a, rr[i].w);
			rd_chk(rr[i].a, rr[i].e);
		end
		$display("test registers done");
		// Clock sources; pause with a run rising edge clears and holds
		wr(6'h10, 8'h00); wr(6'h14, 8'h00); wr(6'h18, 8'h00); wr(6'h04, 8'hC0);
		foreach (ck[i]) begin
			wr(6'h00, 8'h00);
			wr(6'h00, {1'b1, ck[i].sel, 4'h8});
			wr(6'h00, {1'b0, ck[i].sel, 4'h8});
			if (ck[i].sel[2:1] == 2'b11) u_far.burst(10);
			else repeat (1021) @(posedge sys_clk);
			wr(6'h00, {1'b1, ck[i].sel, 4'h8});
			acc(1'b0, 6'h08, 8'h00, lo); acc(1'b0, 6'h0C, 8'h00, hi);
			v = {hi, lo};
			tol = (ck[i].sel[2:1] == 2'b11) ? 0 : 2;
			check({15'h0000, v + tol >= ck[i].e && v <= ck[i].e + tol}, 16'h0001);
		end
		repeat (20) @(posedge sys_clk);
		rd_chk(6'h08, lo);
		$display("test clock select done");
		// Compare mode, clear on A at 16, every pin action
		wr(6'h10, 8'h10);
		for (int a = 0; a < 4; a++) begin
			oc = (a != 2);
			wr(6'h00, 8'h00); wr(6'h1C, 8'h03);
			wr(6'h04, {2'h0, 2'(a), oc, 3'b001});
			wr(6'h00, 8'h18);
			repeat (3) @(posedge sys_clk);
			check(pad, {15'h0000, oc});
			check(oe, 16'h0001);
			repeat (21) @(posedge sys_clk);
			check(pad, {15'h0000, a == 0 || a == 2});
			rd_chk(6'h1C, 8'h01);
		end
		repeat (40) @(posedge sys_clk);
		check(gap, 16'h0010);
		// Clear on P every 256: A match alone moves the pin
		wr(6'h00, 8'h00); wr(6'h18, 8'h01); wr(6'h1C, 8'h03); wr(6'h04, 8'h38);
		wr(6'h00, 8'h18);
		repeat (600) @(posedge sys_clk);
		check(gap, 16'h0100);
		rd_chk(6'h1C, 8'h03);
		// Timer mode, clear on A at 512: pin undriven, P match at 256 unflagged
		wr(6'h00, 8'h00); wr(6'h04, 8'hF9); wr(6'h10, 8'h00); wr(6'h14, 8'h02);
		wr(6'h1C, 8'h03); wr(6'h00, 8'h18);
		repeat (600) @(posedge sys_clk);
		check(oe, 16'h0000);
		rd_chk(6'h1C, 8'h01);
		$display("test compare done");
		// PWM rows: high cycles counted over a whole number of periods
		foreach (pw[i]) begin
			wr(6'h00, 8'h00); wr(6'h04, pw[i].c1);
			wr(6'h10, pw[i].ca[7:0]); wr(6'h14, pw[i].ca[15:8]);
			wr(6'h18, pw[i].cp); wr(6'h1C, 8'h03); wr(6'h00, 8'h18);
			repeat (600) @(posedge sys_clk);
			v = 0;
			repeat (512) begin
				@(posedge sys_clk);
				v += (pad === 1'b1);
			end
			check(16'(v), 16'(pw[i].hi));
			rd_chk(6'h1C, pw[i].f);
		end
		$display("test pwm done");
		// Reset in mid-run: pin released, registers back to zero
		sys_rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		sys_rst <= 1'b0;
		check(oe, 16'h0000);
		check(avl_waitrequest, 16'h0001);
		rd_chk(6'h00, 8'h00);
		rd_chk(6'h08, 8'h00);
		rd_chk(6'h1C, 8'h00);
		$display("test reset done");
		final_report();
	end
endmodule
`default_nettype wire
